// >>> wdc_pkg.sv
// Package: register map, field positions and timing constants of the watchdog
package wdc_pkg;

    // System clock and watchdog oscillator rates
    localparam int unsigned CLK_HZ     = 125_000_000;
    localparam int unsigned OSC_HZ     = 128_000;
    // Oscillator period in system clocks, shortest period so rounded down
    localparam int unsigned OSC_DIV    = CLK_HZ / OSC_HZ;
    // Timeout of the shortest prescale step, in oscillator cycles
    localparam int unsigned BASE_TICKS = 2048;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_DOG_CS  = 8'h21;
    localparam logic [7:0] IDX_CAUSE   = 8'h22;
    localparam logic [7:0] IDX_CMD     = 8'h23;

    // Fields of watchdog_control_status
    localparam int unsigned B_IRQF     = 7;
    localparam int unsigned B_IE       = 6;
    localparam int unsigned B_PS3      = 5;
    localparam int unsigned B_UNLK     = 4;
    localparam int unsigned B_EN       = 3;
    localparam int unsigned B_PS2      = 2;
    localparam int unsigned B_PS0      = 0;

    // Fields of reset_cause_status
    localparam int unsigned B_DOG      = 3;
    localparam int unsigned B_BOR      = 2;
    localparam int unsigned B_PIN      = 1;
    localparam int unsigned B_POR      = 0;
    localparam logic [3:0]  CAUSE_POR  = 4'h1;

    // Fields of the command register
    localparam int unsigned B_KICK     = 0;
    localparam int unsigned B_GIE      = 1;

    // Unlock window length in system clocks
    localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;

    // Prescale select range and counter width
    localparam logic [3:0]  PS_MAX     = 4'h9;
    localparam int unsigned CNT_W      = 21;
    localparam int unsigned DIV_W      = 10;

    // Word index carried by a byte address
    function automatic logic [7:0] reg_index(input logic [9:0] byte_addr);
        reg_index = byte_addr[9:2];
    endfunction

    // Timeout length in oscillator cycles for a prescale code
    function automatic logic [CNT_W-1:0] dog_limit(
        input logic [3:0]  ps,
        input int unsigned base
    );
        logic [3:0] sel;
        sel = (ps > PS_MAX) ? PS_MAX : ps;
        dog_limit = CNT_W'(base) << sel;
    endfunction

endpackage : wdc_pkg

// >>> wdc_timer.sv
// Module: oscillator tick divider and watchdog timeout counter
`timescale 1ns/10ps
module wdc_timer #(
    parameter int unsigned TICK_DIV   = wdc_pkg::OSC_DIV,    // Clocks per tick
    parameter int unsigned BASE_TICKS = wdc_pkg::BASE_TICKS  // Shortest timeout
) (
    input  wire logic clk_sys,     // System clock
    input  wire logic rst,         // Synchronous reset, active high
    wdc_tmr_if.tmr    tmr          // Timer control and timeout
);
    import wdc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [CNT_W-1:0] cnt;
        logic             timeout;
    } wdc_tmr_state_type;

    wdc_tmr_state_type s;
    wdc_tmr_state_type next_s;

    logic             tick;
    logic [CNT_W-1:0] limit;

    // Oscillator tick from the system clock, then count ticks to timeout
    always_comb
    begin
        next_s         = s;
        next_s.timeout = 1'b0;
        tick           = (s.div == DIV_W'(TICK_DIV - 1));
        limit          = dog_limit(tmr.prescale, BASE_TICKS);
        if (tmr.clear)
        begin
            next_s.div = '0;
            next_s.cnt = '0;
        end
        else
        begin
            next_s.div = tick ? '0 : s.div + 1'b1;
            // Compare with >= so a shortened prescale still expires
            if (tick && (s.cnt >= limit - 1'b1))
            begin
                next_s.cnt     = '0;
                next_s.timeout = 1'b1;
            end
            else if (tick)
            begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign tmr.timeout = s.timeout;

endmodule // wdc_timer

// >>> wdc_tmr_if.sv
// Interface: control and timeout signals between register logic and timer
`timescale 1ns/10ps
interface wdc_tmr_if;
    logic       clear;       // Clear counter and divider
    logic [3:0] prescale;    // Prescale select
    logic       timeout;     // One-cycle timeout pulse

    modport ctl (output clear, output prescale, input timeout);
    modport tmr (input clear, input prescale, output timeout);
endinterface : wdc_tmr_if

// >>> wdc_watchdog.sv
// Module: watchdog control, timed unlock and reset cause flags on Avalon-MM
// Functional notes
// - Upper four bits of reset cause register always read zero.
// - Watchdog reset sets its cause flag; power-on or writing zero clears.
// - Brown-out reset sets its flag; power-on or writing zero clears.
// - Pin reset sets its flag; power-on or writing zero clears.
// - Power-on sets its flag; only writing zero clears it.
// - Timeout in interrupt mode sets flag; vector or write one clears.
// - Interrupt requested only with global enable set and watchdog interrupt enable set or cleared by the timeout.
// - Enable and interrupt-enable bits select stopped, irq, reset, irq-first.
// - With enable set, each timeout clears interrupt-enable.
// - Change-unlock bit clears itself four clocks after written one.
// - Enable clears only on a reset or while unlocked, after writing unlock and enable.
// - Prescale writes take effect only while unlock bit is set.
// - Writing enable one always enables; zero only under unlock.
// - Higher safety level never allows the watchdog to be disabled.
// - Lower level forces enable while watchdog cause flag is set.
// - Prescale codes 0 to 9 give 2K doubling up to 1024K cycles.
// - Counter runs from 128 kHz oscillator ticks.
// - Counter cleared by kick, when disabled, and on any chip reset.
// - Fuse picks safety level; lower starts disabled, higher always on.
// - Reset-mode timeout gives a one-clock reset pulse.
`timescale 1ns/10ps
module wdc_watchdog #(
    parameter int unsigned TICK_DIV   = wdc_pkg::OSC_DIV,    // Clocks per tick
    parameter int unsigned BASE_TICKS = wdc_pkg::BASE_TICKS  // Shortest timeout
) (
    input  wire logic        clk_sys,          // System clock, 125 MHz
    input  wire logic        rst,              // Power-on reset, active high
    input  wire logic        dog_always_on_fuse, // Safety level 2 fuse
    input  wire logic        brownout_event,   // Brown-out reset pulse
    input  wire logic        pin_reset_event,  // External pin reset pulse
    input  wire logic        irq_vector_taken, // Timeout vector executed
    input  wire logic [9:0]  avs_address,      // Byte address
    input  wire logic        avs_read,         // Read request
    input  wire logic        avs_write,        // Write request
    input  wire logic [31:0] avs_writedata,    // Write data
    input  wire logic [3:0]  avs_byteenable,   // Byte enables
    output logic      [31:0] avs_readdata,     // Read data
    output logic             avs_waitrequest,  // Wait request
    output logic             dog_irq_req,      // Timeout interrupt request
    output logic             dog_reset_pulse   // Chip reset from watchdog
);
    import wdc_pkg::*;

    typedef struct packed {
        logic        ack;       // Second cycle of a bus access
        logic [31:0] rdata;     // Read data register
        logic        safety2;   // Fuse captured at power-on
        logic        en;        // dog_enable as written
        logic        ie;        // dog_timeout_irq_enable
        logic        irqf;      // dog_timeout_irq_flag
        logic        irq_kept;  // Request outlives hardware ie clear
        logic [3:0]  psel;      // dog_prescale_select
        logic [2:0]  unlock;    // Unlock window countdown
        logic [3:0]  cause;     // reset_cause_status flags
        logic        gie;       // Global interrupt enable
        logic        dog_rst;   // Reset pulse register
    } wdc_ctl_state_type;

    wdc_ctl_state_type s;
    wdc_ctl_state_type next_s;

    wdc_tmr_if tmr_bus ();

    logic       req;
    logic       acc;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] idx;
    logic       unlocked;
    logic       en_eff;
    logic       running;
    logic       kick;
    logic       dog_chip_rst;
    logic       chip_rst;

    // Timeout counter on oscillator ticks
    wdc_timer #(
        .TICK_DIV   (TICK_DIV),
        .BASE_TICKS (BASE_TICKS)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tmr     (tmr_bus.tmr)
    );

    // Bus decode: one wait state, the access completes on the ack cycle
    always_comb
    begin
        req      = avs_read | avs_write;
        acc      = req & s.ack;
        wr       = avs_write & acc & avs_byteenable[0];
        wdata    = avs_writedata[7:0];
        idx      = reg_index(avs_address);
        unlocked = (s.unlock != '0);
    end

    // Effective enable: level 2 always on, level 1 held by dog cause flag
    always_comb
    begin
        en_eff  = s.en | s.safety2
                | (~s.safety2 & s.cause[B_DOG]);
        running = en_eff | s.ie;
    end

    // Timeout handling and chip reset sources
    always_comb
    begin
        dog_chip_rst = tmr_bus.timeout & ~s.ie & en_eff;
        chip_rst     = dog_chip_rst | brownout_event | pin_reset_event;
        kick         = wr && (idx == IDX_CMD) && wdata[B_KICK];
    end

    // Timer control; a stopped timer is held cleared
    always_comb
    begin
        tmr_bus.clear    = chip_rst | kick | ~running;
        tmr_bus.prescale = s.psel;
    end

    // Next state of the register file
    always_comb
    begin
        next_s         = s;
        next_s.ack     = req & ~s.ack;
        next_s.dog_rst = 1'b0;

        // Unlock window counts down on its own
        if (unlocked)
            next_s.unlock = s.unlock - 1'b1;

        // Read data captured in the first cycle of a read
        if (avs_read && !s.ack)
        begin
            next_s.rdata = '0;
            case (idx)
                IDX_DOG_CS:
                begin
                    next_s.rdata[B_IRQF] = s.irqf;
                    next_s.rdata[B_IE]   = s.ie;
                    next_s.rdata[B_PS3]  = s.psel[3];
                    next_s.rdata[B_UNLK] = unlocked;
                    next_s.rdata[B_EN]   = en_eff;
                    next_s.rdata[B_PS2:B_PS0] = s.psel[2:0];
                end
                IDX_CAUSE:
                    next_s.rdata[3:0] = s.cause;
                IDX_CMD:
                    next_s.rdata[B_GIE] = s.gie;
                default:
                    next_s.rdata = '0;
            endcase
        end

        // Register writes
        if (wr)
        begin
            case (idx)
                IDX_DOG_CS:
                begin
                    next_s.ie = wdata[B_IE];
                    next_s.irq_kept = 1'b0;
                    if (wdata[B_IRQF])
                        next_s.irqf = 1'b0;
                    // Window opens only on unlock and enable written together
                    if (wdata[B_UNLK] && wdata[B_EN])
                        next_s.unlock = UNLOCK_CYCLES;
                    if (wdata[B_EN])
                        next_s.en = 1'b1;
                    else if (unlocked && !s.safety2 && !s.cause[B_DOG])
                        next_s.en = 1'b0;
                    if (unlocked)
                        next_s.psel = {wdata[B_PS3],
                                       wdata[B_PS2:B_PS0]};
                end
                IDX_CAUSE:
                    // Writing zero clears; writing one leaves a flag alone
                    next_s.cause = s.cause & wdata[3:0];
                IDX_CMD:
                    next_s.gie = wdata[B_GIE];
                default:
                    next_s.gie = s.gie;
            endcase
        end

        // Vector execution acknowledges the interrupt
        if (irq_vector_taken)
        begin
            next_s.irqf     = 1'b0;
            next_s.irq_kept = 1'b0;
        end

        // Timeout in interrupt mode; a set beats a same-cycle vector or write clear, a chip reset beats the set
        if (tmr_bus.timeout && s.ie)
        begin
            next_s.irqf = 1'b1;
            // Keep the request alive, else irq-first mode never interrupts
            if (en_eff)
            begin
                next_s.ie       = 1'b0;
                next_s.irq_kept = 1'b1;
            end
        end

        // Timeout in reset mode gives a single clock pulse
        if (dog_chip_rst)
            next_s.dog_rst = 1'b1;

        // Any chip reset returns the control state to its start values
        if (chip_rst)
        begin
            next_s.en     = 1'b0;
            next_s.ie     = 1'b0;
            next_s.irqf   = 1'b0;
            next_s.irq_kept = 1'b0;
            next_s.psel   = '0;
            next_s.unlock = '0;
            next_s.gie    = 1'b0;
        end

        // Cause flags set last so they win over a same-cycle clear
        if (dog_chip_rst)
            next_s.cause[B_DOG] = 1'b1;
        if (brownout_event)
            next_s.cause[B_BOR] = 1'b1;
        if (pin_reset_event)
            next_s.cause[B_PIN] = 1'b1;
    end

    // State register; power-on sets only the power-on flag, captures fuse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s         <= '0;
            s.cause   <= CAUSE_POR;
            s.safety2 <= dog_always_on_fuse;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs
    assign avs_waitrequest = req & ~s.ack;
    assign avs_readdata    = s.rdata;
    // An enable cleared by the timeout itself still serves that request
    assign dog_irq_req     = s.irqf & (s.ie | s.irq_kept) & s.gie;
    assign dog_reset_pulse = s.dog_rst;

endmodule // wdc_watchdog

// >>> wdc_watchdog_props.sv
// Checker: bus handshake, pulses and readback of the watchdog
`timescale 1ns/10ps
module wdc_watchdog_props #(
    parameter int unsigned TICK_DIV   = wdc_pkg::OSC_DIV,   // Tick
    parameter int unsigned BASE_TICKS = wdc_pkg::BASE_TICKS // Base
) (
    input wire logic        clk_sys,            // Clock
    input wire logic        rst,                // Reset
    input wire logic        dog_always_on_fuse, // Fuse
    input wire logic        brownout_event,     // Brown-out
    input wire logic        pin_reset_event,    // Pin reset
    input wire logic        irq_vector_taken,   // Vector
    input wire logic [9:0]  avs_address,        // Address
    input wire logic        avs_read,           // Read
    input wire logic        avs_write,          // Write
    input wire logic [31:0] avs_writedata,      // Wdata
    input wire logic [3:0]  avs_byteenable,     // Enables
    input wire logic [31:0] avs_readdata,       // Rdata
    input wire logic        avs_waitrequest,    // Wait
    input wire logic        dog_irq_req,        // Irq
    input wire logic        dog_reset_pulse     // Pulse
);
    import wdc_pkg::*;
    // Transfer helpers; a transfer is taken when waitrequest is low
    wire logic       req  = avs_read | avs_write;
    wire logic       take = req & ~avs_waitrequest;
    wire logic [7:0] idx  = avs_address[9:2];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_unlock;
        take && avs_write && idx == IDX_DOG_CS && avs_byteenable[0]
            && avs_writedata[B_UNLK] && avs_writedata[B_EN];
    endsequence
    a_first_wait: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    a_cause_upper: assert property (
        take && avs_read && idx == IDX_CAUSE |-> avs_readdata[31:4] == '0)
        else $error("cause register upper bits set");
    a_unmapped_zero: assert property (take && avs_read
        && (idx < IDX_DOG_CS || idx > IDX_CMD) |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    a_pulse_single: assert property (
        dog_reset_pulse |=> !dog_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_vector_clears: assert property (
        irq_vector_taken |=> !dog_irq_req)
        else $error("irq request survived the vector");
    a_unlock_reads: assert property (
        s_unlock ##1 (avs_read && idx == IDX_DOG_CS) ##1 take
        |-> avs_readdata[B_UNLK]) else $error("unlock window not visible");
    a_quiet_release: assert property (
        $fell(rst) |-> !dog_reset_pulse && !dog_irq_req)
        else $error("outputs active after reset");
    c_pulse: cover property (dog_reset_pulse);
    c_irq: cover property (dog_irq_req);
    c_unlock: cover property (s_unlock);
endmodule // wdc_watchdog_props

bind wdc_watchdog wdc_watchdog_props #(
    .TICK_DIV(TICK_DIV), .BASE_TICKS(BASE_TICKS)
) wdc_watchdog_props_i (
    .clk_sys(clk_sys), .rst(rst), .dog_always_on_fuse(dog_always_on_fuse),
    .brownout_event(brownout_event), .pin_reset_event(pin_reset_event),
    .irq_vector_taken(irq_vector_taken), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dog_irq_req(dog_irq_req), .dog_reset_pulse(dog_reset_pulse)
);

// >>> wdc_watchdog_tb.sv
// Testbench: registers, timed unlock, timeouts and reset causes
`timescale 1ns/10ps
module wdc_watchdog_tb;
    import wdc_pkg::*;
    typedef struct packed {logic r; logic [9:0] a; logic [7:0] d;
        logic [3:0] b;} wdc_row_type;
    logic        clk_sys = 1'b0, rst = 1'b1, fuse = 1'b0;
    logic        bor = 1'b0, pin = 1'b0, vec = 1'b0, rq = 1'b0, wq = 1'b0;
    logic [9:0]  addr = '0;
    logic [3:0]  be = '0;
    logic [31:0] wdata = '0, rdata, q;
    logic        wreq, irq, pulse;
    int          err_total = 0, n_compared = 0;
    // Plain cases: read rows compare, write rows only drive
    wdc_row_type rows [19] = '{
        '{1'h1, 10'h088, 8'h01, 4'h1}, '{1'h1, 10'h084, 8'h00, 4'h1},
        '{1'h1, 10'h100, 8'h00, 4'h1}, '{1'h0, 10'h100, 8'hff, 4'h1},
        '{1'h0, 10'h088, 8'hfe, 4'h1}, '{1'h1, 10'h088, 8'h00, 4'h1},
        '{1'h0, 10'h084, 8'h08, 4'h0}, '{1'h1, 10'h084, 8'h00, 4'h1},
        '{1'h0, 10'h084, 8'h08, 4'h1}, '{1'h1, 10'h084, 8'h08, 4'h1},
        '{1'h0, 10'h084, 8'h18, 4'h1}, '{1'h0, 10'h084, 8'h0f, 4'h1},
        '{1'h1, 10'h084, 8'h1f, 4'h1}, '{1'h0, 10'h084, 8'h00, 4'h1},
        '{1'h1, 10'h084, 8'h0f, 4'h1}, '{1'h0, 10'h08c, 8'h01, 4'h1},
        '{1'h0, 10'h084, 8'h18, 4'h1}, '{1'h0, 10'h084, 8'h00, 4'h1},
        '{1'h1, 10'h084, 8'h10, 4'h1}};
    // Short counts keep timeouts within a few hundred clocks
    wdc_watchdog #(.TICK_DIV(8), .BASE_TICKS(4)) wdc_watchdog_i (
        .clk_sys(clk_sys), .rst(rst), .dog_always_on_fuse(fuse),
        .brownout_event(bor), .pin_reset_event(pin), .irq_vector_taken(vec),
        .avs_address(addr), .avs_read(rq), .avs_write(wq),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .dog_irq_req(irq), .dog_reset_pulse(pulse)
    );
    always #4 clk_sys = ~clk_sys;
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    // One transfer; held until waitrequest samples low, no release
    task automatic acc(input logic r, input logic [9:0] a,
        input logic [7:0] d, input logic [3:0] b);
        int k;
        rq <= r;
        wq <= !r;
        addr <= a;
        wdata <= 32'(d);
        be <= b;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (wreq !== 1'b0 && k < 20);
        q = rdata;
        if (wreq !== 1'b0)
        begin
            err_total++;
            summarize();
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00, 4'h1);
        chk($sformatf("reg %h", a), q, 32'(e));
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        acc(1'b0, a, d, 4'h1);
    endtask
    // One-cycle event with the bus idle, then a quiet cycle
    task automatic ev(input int s);
        rq <= 1'b0;
        wq <= 1'b0;
        {bor, pin, vec} <= {s == 1, s == 2, s == 3};
        @(posedge clk_sys);
        {bor, pin, vec} <= 3'h0;
        @(posedge clk_sys);
    endtask
    // Bounded wait for the irq request or the reset pulse
    task automatic wait_out(input logic sel, input int lim);
        int k;
        rq <= 1'b0;
        wq <= 1'b0;
        for (k = 0; k < lim; k++)
        begin
            @(posedge clk_sys);
            if ((sel ? irq : pulse) === 1'b1)
                break;
        end
        chk("timeout seen", 32'(k < lim), 32'h0000_0001);
        if (k == lim)
            summarize();
    endtask
    task automatic do_reset(input logic f);
        {rst, fuse, rq, wq} <= {1'b1, f, 2'h0};
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Main sequence: table first, then the awkward cases
    initial
    begin
        do_reset(1'b0);
        foreach (rows[i])
        begin
            acc(rows[i].r, rows[i].a, rows[i].d, rows[i].b);
            if (rows[i].r)
                chk($sformatf("row %0d", i), q, 32'(rows[i].d));
        end
        $display("done: register rows");
        wr(10'h08c, 8'h02);
        wr(10'h084, 8'h18);
        wr(10'h084, 8'h43);
        wait_out(1'b1, 400);
        rd(10'h084, 8'hc3);
        ev(3);
        rd(10'h084, 8'h43);
        wait_out(1'b1, 400);
        wr(10'h084, 8'hc3);
        rd(10'h084, 8'h43);
        wr(10'h08c, 8'h00);
        repeat (150)
        begin
            ev(0);
            chk("irq gated", 32'(irq), 32'h0000_0000);
        end
        rd(10'h084, 8'hc3);
        wr(10'h08c, 8'h02);
        ev(0);
        chk("irq open", 32'(irq), 32'h0000_0001);
        $display("done: interrupt mode");
        wr(10'h084, 8'h18);
        wr(10'h084, 8'hcb);
        wait_out(1'b1, 400);
        rd(10'h084, 8'h8b);
        ev(3);
        wait_out(1'b0, 400);
        wr(10'h08c, 8'h01);
        rd(10'h088, 8'h08);
        rd(10'h084, 8'h08);
        wr(10'h084, 8'h18);
        wr(10'h084, 8'h00);
        rd(10'h084, 8'h18);
        wr(10'h088, 8'h00);
        rd(10'h088, 8'h00);
        wr(10'h08c, 8'h01);
        wr(10'h084, 8'h18);
        rd(10'h084, 8'h18);
        repeat (3) ev(0);
        rd(10'h084, 8'h08);
        wr(10'h084, 8'h00);
        rd(10'h084, 8'h08);
        wr(10'h084, 8'h18);
        wr(10'h084, 8'h00);
        rd(10'h084, 8'h10);
        $display("done: reset mode and unlock");
        ev(2);
        rd(10'h088, 8'h02);
        ev(1);
        rd(10'h088, 8'h06);
        wr(10'h088, 8'hfb);
        rd(10'h088, 8'h02);
        do_reset(1'b1);
        rd(10'h088, 8'h01);
        wr(10'h08c, 8'h01);
        rd(10'h084, 8'h08);
        ev(1);
        rd(10'h088, 8'h05);
        wr(10'h084, 8'h18);
        wr(10'h084, 8'h00);
        rd(10'h084, 8'h18);
        wait_out(1'b0, 100);
        rd(10'h088, 8'h0d);
        $display("done: causes and level two");
        summarize();
    end
endmodule // wdc_watchdog_tb
